// ===== src/tpc_pkg.sv
package tpc_pkg;

	// panel key positions in the key vector
	localparam int KEY_N       = 9;
	localparam int K_MOUNT     = 0;
	localparam int K_DISMOUNT  = 1;
	localparam int K_ATTACH    = 2;
	localparam int K_RESET     = 3;
	localparam int K_STANDBY   = 4;
	localparam int K_POWERUP   = 5;
	localparam int K_MAINT     = 6;
	localparam int K_ADVANCE   = 7;
	localparam int K_RUN       = 8;

	// register byte offsets on the bus
	localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
	localparam logic [7:0] REG_STATUS_OFS = 8'h04;
	localparam logic [7:0] REG_DISP_OFS   = 8'h08;

	// control register fields and reset value
	localparam int         CTRL_ADDR_LSB = 0;
	localparam int         ADDR_W        = 4;
	localparam logic [3:0] UNIT_ADDR_RST = 4'h0;

	// status register field positions
	localparam int ST_POS_LSB   = 0;
	localparam int ST_OP_LSB    = 2;
	localparam int ST_ONLINE    = 5;
	localparam int ST_PENDING   = 6;
	localparam int ST_FAULT     = 7;
	localparam int ST_DIAG      = 8;
	localparam int ST_POWERED   = 9;
	localparam int ST_WR_BLOCK  = 10;

	// display reset value and first test number (two bcd digits)
	localparam logic [7:0] DISP_RST      = 8'h00;
	localparam logic [7:0] TEST_NUM_RST  = 8'h01;

	// lamp test after power-up
	localparam int LAMP_TEST_NS     = 2000;
	localparam int CLK_PERIOD_NS    = 4;
	localparam int LAMP_TEST_CYCLES = (LAMP_TEST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LAMP_CNT_W       = 10;

	// commands to the motion sequencer
	localparam logic [2:0] CMD_NONE        = 3'h0;
	localparam logic [2:0] CMD_LOAD        = 3'h1;
	localparam logic [2:0] CMD_REWIND      = 3'h2;
	localparam logic [2:0] CMD_UNLOAD      = 3'h3;
	localparam logic [2:0] CMD_SLOW_UNLOAD = 3'h4;
	localparam logic [2:0] CMD_HALT        = 3'h5;

	typedef enum logic [1:0] {
		POS_NONE,
		POS_THREADED,
		POS_AT_MARK,
		POS_BEYOND
	} tpc_pos_t;

	typedef enum logic [2:0] {
		OP_IDLE,
		OP_LOADING,
		OP_REWINDING,
		OP_REW_UNLOAD,
		OP_UNLOADING
	} tpc_op_t;

	typedef enum logic [1:0] {
		PWR_STANDBY,
		PWR_LAMP_TEST,
		PWR_ON
	} tpc_pwr_t;

endpackage

// ===== src/tpc_key_edge.sv
`timescale 1ns/100ps
module tpc_key_edge
	import tpc_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [KEY_N-1:0] key_i,
	output logic      [KEY_N-1:0] press_o
);

	logic [KEY_N-1:0] meta_reg;
	logic [KEY_N-1:0] sync_reg;
	logic [KEY_N-1:0] prev_reg;

	// two-stage synchroniser, then a history stage for edge detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= key_i;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// rising edge only: a held key gives one pulse
	assign press_o = sync_reg & ~prev_reg;

endmodule

// ===== src/tpc_panel_ctrl.sv
`timescale 1ns/100ps
module tpc_panel_ctrl
	import tpc_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	input  wire logic              wb_we_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	output logic                   wb_ack_o,
	input  wire logic [KEY_N-1:0]  key_i,
	input  wire logic              threaded_sense_i,
	input  wire logic              marker_sense_i,
	input  wire logic              ring_sense_i,
	input  wire logic [ADDR_W-1:0] host_addr_i,
	input  wire logic              seq_done_i,
	input  wire logic              seq_fault_i,
	input  wire logic [7:0]        seq_fault_code_i,
	output logic [2:0]             seq_cmd_o,
	output logic                   seq_cmd_valid_o,
	output logic                   online_o,
	output logic                   write_block_o,
	output logic                   test_start_o,
	output logic [7:0]             test_num_o,
	output logic                   lamp_standby_o,
	output logic                   lamp_power_o,
	output logic                   lamp_online_o,
	output logic                   lamp_reset_o,
	output logic                   lamp_diag_o,
	output logic                   lamp_match_o,
	output logic                   lamp_marker_o,
	output logic                   write_inhibit_lamp_o,
	output logic [7:0]             display_o
);

	// two-digit bcd increment, wraps 99 to 00
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (v[3:0] == 4'h9) begin
			r[3:0] = 4'h0;
			r[7:4] = (v[7:4] == 4'h9) ? 4'h0 : v[7:4] + 4'h1;
		end else begin
			r[3:0] = v[3:0] + 4'h1;
		end
		return r;
	endfunction

	logic [KEY_N-1:0]  press;
	logic [2:0]        sen_meta_reg;
	logic [2:0]        sen_reg;
	logic [ADDR_W-1:0] haddr_meta_reg;
	logic [ADDR_W-1:0] haddr_reg;
	logic [ADDR_W-1:0] unit_addr_reg;
	tpc_pos_t          pos_reg;
	tpc_op_t           op_reg;
	tpc_pwr_t          pwr_reg;
	logic [LAMP_CNT_W-1:0] lamp_cnt_reg;
	logic              online_reg;
	logic              pending_reg;
	logic              fault_reg;
	logic [7:0]        fault_code_reg;
	logic              diag_reg;
	logic [7:0]        test_num_reg;
	logic              loaded;
	logic              keys_ok;
	logic              powered;
	logic              lamp_all;

	tpc_key_edge u_keys (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.key_i   (key_i),
		.press_o (press)
	);

	// sensors and host address arrive from pins: two flops first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sen_meta_reg   <= '0;
			sen_reg        <= '0;
			haddr_meta_reg <= '0;
			haddr_reg      <= '0;
		end else begin
			sen_meta_reg   <= {ring_sense_i, marker_sense_i, threaded_sense_i};
			sen_reg        <= sen_meta_reg;
			haddr_meta_reg <= host_addr_i;
			haddr_reg      <= haddr_meta_reg;
		end
	end

	assign powered = (pwr_reg == PWR_ON);
	assign loaded  = (pos_reg == POS_AT_MARK) || (pos_reg == POS_BEYOND);
	assign keys_ok = powered && !online_reg && !fault_reg && !diag_reg;
	assign lamp_all = (pwr_reg == PWR_LAMP_TEST);

	// power sequencing; standby key wins from any state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_reg      <= PWR_STANDBY;
			lamp_cnt_reg <= '0;
		end else if (press[K_STANDBY]) begin
			pwr_reg      <= PWR_STANDBY;
			lamp_cnt_reg <= '0;
		end else begin
			case (pwr_reg)
				PWR_STANDBY: begin
					if (press[K_POWERUP]) begin
						pwr_reg      <= PWR_LAMP_TEST;
						lamp_cnt_reg <= '0;
					end
				end
				PWR_LAMP_TEST: begin
					if (lamp_cnt_reg == LAMP_CNT_W'(LAMP_TEST_CYCLES - 1)) begin
						pwr_reg <= PWR_ON;
					end else begin
						lamp_cnt_reg <= lamp_cnt_reg + 1'b1;
					end
				end
				PWR_ON: pwr_reg <= PWR_ON;
				default: pwr_reg <= PWR_STANDBY;
			endcase
		end
	end

	// tape position from sensors and completed loads
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_reg <= POS_NONE;
		end else if (!sen_reg[0]) begin
			pos_reg <= POS_NONE;
		end else if (loaded) begin
			pos_reg <= sen_reg[1] ? POS_AT_MARK : POS_BEYOND;
		end else if (op_reg == OP_LOADING && seq_done_i) begin
			pos_reg <= POS_AT_MARK;
		end else if (pos_reg == POS_NONE) begin
			pos_reg <= POS_THREADED;
		end
	end

	// tape operation and sequencer commands
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_reg          <= OP_IDLE;
			seq_cmd_o       <= CMD_NONE;
			seq_cmd_valid_o <= 1'b0;
		end else begin
			seq_cmd_o       <= CMD_NONE;
			seq_cmd_valid_o <= 1'b0;
			if (press[K_RESET] || press[K_STANDBY] || seq_fault_i) begin
				op_reg          <= OP_IDLE;
				seq_cmd_o       <= CMD_HALT;
				seq_cmd_valid_o <= 1'b1;
			end else if (op_reg != OP_IDLE) begin
				if (seq_done_i) begin
					if (op_reg == OP_REW_UNLOAD) begin
						op_reg          <= OP_UNLOADING;
						seq_cmd_o       <= CMD_UNLOAD;
						seq_cmd_valid_o <= 1'b1;
					end else begin
						op_reg <= OP_IDLE;
					end
				end
			end else if (keys_ok && press[K_MOUNT]) begin
				if (loaded) begin
					op_reg          <= OP_REWINDING;
					seq_cmd_o       <= CMD_REWIND;
					seq_cmd_valid_o <= 1'b1;
				end else if (pos_reg == POS_THREADED) begin
					op_reg          <= OP_LOADING;
					seq_cmd_o       <= CMD_LOAD;
					seq_cmd_valid_o <= 1'b1;
				end
			end else if (keys_ok && press[K_DISMOUNT]) begin
				case (pos_reg)
					POS_AT_MARK: begin
						op_reg          <= OP_UNLOADING;
						seq_cmd_o       <= CMD_UNLOAD;
						seq_cmd_valid_o <= 1'b1;
					end
					POS_BEYOND: begin
						op_reg          <= OP_REW_UNLOAD;
						seq_cmd_o       <= CMD_REWIND;
						seq_cmd_valid_o <= 1'b1;
					end
					POS_THREADED: begin
						op_reg          <= OP_UNLOADING;
						seq_cmd_o       <= CMD_SLOW_UNLOAD;
						seq_cmd_valid_o <= 1'b1;
					end
					default: op_reg <= OP_IDLE;
				endcase
			end
		end
	end

	// on-line state and remembered attach request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			online_reg  <= 1'b0;
			pending_reg <= 1'b0;
		end else if (press[K_RESET] || press[K_STANDBY] || seq_fault_i) begin
			online_reg  <= 1'b0;
			pending_reg <= 1'b0;
		end else if (op_reg == OP_LOADING && seq_done_i && pending_reg) begin
			online_reg  <= 1'b1;
			pending_reg <= 1'b0;
		end else if (keys_ok && press[K_ATTACH]) begin
			if (op_reg == OP_LOADING) begin
				pending_reg <= 1'b1;
			end else if (loaded && op_reg == OP_IDLE) begin
				online_reg <= 1'b1;
			end
		end
	end

	// fault status; a fault in the reset cycle survives the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_reg      <= 1'b0;
			fault_code_reg <= DISP_RST;
		end else if (seq_fault_i) begin
			fault_reg      <= 1'b1;
			fault_code_reg <= seq_fault_code_i;
		end else if (press[K_RESET]) begin
			fault_reg <= 1'b0;
		end
	end

	// diagnostic mode and test selection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			diag_reg     <= 1'b0;
			test_num_reg <= TEST_NUM_RST;
			test_start_o <= 1'b0;
		end else begin
			test_start_o <= 1'b0;
			if (press[K_RESET] || press[K_STANDBY]) begin
				diag_reg <= 1'b0;
			end else if (!diag_reg) begin
				if (keys_ok && press[K_MAINT] && pos_reg == POS_THREADED && op_reg == OP_IDLE) begin
					diag_reg     <= 1'b1;
					test_num_reg <= TEST_NUM_RST;
				end
			end else if (!fault_reg) begin
				if (press[K_ADVANCE]) begin
					test_num_reg <= bcd_inc(test_num_reg);
				end else if (press[K_RUN]) begin
					test_start_o <= 1'b1;
				end
			end
		end
	end

	// lamps and display, all registered; lamp test forces every lamp but the standby lamp on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lamp_standby_o       <= 1'b1;
			lamp_power_o         <= 1'b0;
			lamp_online_o        <= 1'b0;
			lamp_reset_o         <= 1'b0;
			lamp_diag_o          <= 1'b0;
			lamp_match_o         <= 1'b0;
			lamp_marker_o        <= 1'b0;
			write_inhibit_lamp_o <= 1'b0;
			write_block_o        <= 1'b1;
			online_o             <= 1'b0;
			display_o            <= DISP_RST;
			test_num_o           <= TEST_NUM_RST;
		end else begin
			lamp_standby_o <= (pwr_reg == PWR_STANDBY);
			lamp_power_o   <= powered || lamp_all;
			lamp_online_o  <= (powered && online_reg) || lamp_all;
			// reset lamp on fault or diagnostics
			lamp_reset_o   <= (powered && (fault_reg || diag_reg)) || lamp_all;
			lamp_diag_o    <= (powered && diag_reg) || lamp_all;
			lamp_match_o   <= (powered && !diag_reg && haddr_reg == unit_addr_reg) || lamp_all;
			lamp_marker_o  <= (powered && pos_reg == POS_AT_MARK) || lamp_all;
			write_inhibit_lamp_o <= ((pwr_reg != PWR_STANDBY) && !sen_reg[2]) || lamp_all;
			write_block_o        <= !sen_reg[2] || !powered;
			online_o             <= powered && online_reg;
			display_o  <= fault_reg ? fault_code_reg : (diag_reg ? test_num_reg : DISP_RST);
			test_num_o <= test_num_reg;
		end
	end

	// wishbone slave: ack one cycle after strobe, dropped the next
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= '0;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
				case (wb_adr_i)
					REG_CTRL_OFS:   wb_dat_o[CTRL_ADDR_LSB +: ADDR_W] <= unit_addr_reg;
					REG_STATUS_OFS: begin
						wb_dat_o[ST_POS_LSB +: 2] <= pos_reg;
						wb_dat_o[ST_OP_LSB +: 3]  <= op_reg;
						wb_dat_o[ST_ONLINE]       <= online_reg;
						wb_dat_o[ST_PENDING]      <= pending_reg;
						wb_dat_o[ST_FAULT]        <= fault_reg;
						wb_dat_o[ST_DIAG]         <= diag_reg;
						wb_dat_o[ST_POWERED]      <= powered;
						wb_dat_o[ST_WR_BLOCK]     <= write_block_o;
					end
					REG_DISP_OFS:   wb_dat_o[7:0] <= display_o;
					default:        wb_dat_o <= '0;
				endcase
			end
		end
	end

	// unit address, written through byte lane 0
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unit_addr_reg <= UNIT_ADDR_RST;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
			&& wb_adr_i == REG_CTRL_OFS) begin
			unit_addr_reg <= wb_dat_i[CTRL_ADDR_LSB +: ADDR_W];
		end
	end

	// checks
	sequence s_reset_press;
		press[K_RESET] && !seq_fault_i;
	endsequence

	sequence s_halted;
		seq_cmd_valid_o && seq_cmd_o == CMD_HALT && op_reg == OP_IDLE;
	endsequence

	AST_RESET_HALTS: assert property (@(posedge clk_i) disable iff (rst_i)
		s_reset_press |=> s_halted ##0 !online_reg ##0 !fault_reg)
		else $error("reset key did not halt and go off-line");

	AST_RESET_CLEARS_DIAG: assert property (@(posedge clk_i) disable iff (rst_i)
		powered ##0 s_reset_press |=> !diag_reg ##1 !lamp_reset_o)
		else $error("reset key left diagnostics or reset lamp");

	AST_LOAD_START: assert property (@(posedge clk_i) disable iff (rst_i)
		keys_ok && press[K_MOUNT] && op_reg == OP_IDLE && pos_reg == POS_THREADED
		&& !press[K_RESET] && !press[K_STANDBY] && !seq_fault_i
		|=> seq_cmd_valid_o && seq_cmd_o == CMD_LOAD && op_reg == OP_LOADING)
		else $error("mount key did not start a load");

	AST_REW_THEN_UNLOAD: assert property (@(posedge clk_i) disable iff (rst_i)
		op_reg == OP_REW_UNLOAD && seq_done_i && !press[K_RESET] && !press[K_STANDBY]
		&& !seq_fault_i |=> seq_cmd_o == CMD_UNLOAD && op_reg == OP_UNLOADING)
		else $error("unload did not follow rewind");

	AST_PENDING_ONLINE: assert property (@(posedge clk_i) disable iff (rst_i)
		pending_reg && op_reg == OP_LOADING && seq_done_i && !press[K_RESET]
		&& !press[K_STANDBY] && !seq_fault_i |=> online_reg ##1 lamp_online_o)
		else $error("remembered attach did not go on-line");

	AST_ONLINE_LOCKS: assert property (@(posedge clk_i) disable iff (rst_i)
		online_reg && op_reg == OP_IDLE |=> !seq_cmd_valid_o || seq_cmd_o == CMD_HALT)
		else $error("panel key acted while on-line");

	AST_RESET_LAMP: assert property (@(posedge clk_i) disable iff (rst_i)
		powered && (fault_reg || diag_reg) |=> lamp_reset_o)
		else $error("reset lamp dark in fault or diagnostic status");

	AST_ADVANCE: assert property (@(posedge clk_i) disable iff (rst_i)
		diag_reg && !fault_reg && press[K_ADVANCE] && !press[K_RESET] && !press[K_STANDBY]
		|=> test_num_reg == bcd_inc($past(test_num_reg)))
		else $error("advance key did not step the test number");

	AST_MATCH: assert property (@(posedge clk_i) disable iff (rst_i)
		lamp_match_o && !$past(lamp_all) |-> !$past(diag_reg)
		&& $past(haddr_reg) == $past(unit_addr_reg))
		else $error("match lamp lit without address match");

	AST_WRITE_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
		!sen_reg[2] |=> write_block_o)
		else $error("writes not blocked without ring");

endmodule

// ===== sim/tpc_seq_model.sv
`timescale 1ns/100ps
module tpc_seq_model
	import tpc_pkg::*;
#(
	parameter int DONE_DLY = 20
)(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [2:0] cmd_i,
	input  wire logic       cmd_valid_i,
	output logic            done_o
);
	int cnt_reg;

	// one done pulse per motion command; a halt cancels the pending one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 0;
			done_o  <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (cmd_valid_i) begin
				cnt_reg <= (cmd_i == CMD_HALT || cmd_i == CMD_NONE) ? 0 : DONE_DLY;
			end else if (cnt_reg == 1) begin
				done_o  <= 1'b1;
				cnt_reg <= 0;
			end else if (cnt_reg != 0) begin
				cnt_reg <= cnt_reg - 1;
			end
		end
	end
endmodule

// ===== sim/tpc_panel_ctrl_bench.sv
`timescale 1ns/100ps
module tpc_panel_ctrl_bench;
	import tpc_pkg::*;
	typedef struct {int k; logic m; logic [2:0] c0; logic [2:0] c1; logic t;} tpc_row_t;
	logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
	logic [7:0] wb_adr_i = 8'h00, seq_fault_code_i = 8'h00, display_o, test_num_o;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic [3:0] wb_sel_i = 4'h0, host_addr_i = 4'h0;
	logic [KEY_N-1:0] key_i = '0;
	logic threaded_sense_i = 1, marker_sense_i = 1, ring_sense_i = 0, seq_fault_i = 0;
	logic wb_ack_o, seq_done_i, seq_cmd_valid_o, online_o, write_block_o, test_start_o;
	logic lamp_standby_o, lamp_power_o, lamp_online_o, lamp_reset_o, lamp_diag_o;
	logic lamp_match_o, lamp_marker_o, write_inhibit_lamp_o;
	logic [2:0] seq_cmd_o;
	logic [2:0] cmd_q[$];
	logic [7:0] run_q[$];
	int miscompares = 0, samples_checked = 0;
	tpc_row_t rows[7] = '{
		'{K_MOUNT, 1, CMD_LOAD, CMD_NONE, 0},
		'{K_MOUNT, 0, CMD_REWIND, CMD_NONE, 0},
		'{K_DISMOUNT, 0, CMD_REWIND, CMD_UNLOAD, 0},
		'{K_DISMOUNT, 0, CMD_SLOW_UNLOAD, CMD_NONE, 1},
		'{K_MOUNT, 1, CMD_LOAD, CMD_NONE, 0},
		'{K_DISMOUNT, 1, CMD_UNLOAD, CMD_NONE, 0},
		'{K_ADVANCE, 1, CMD_NONE, CMD_NONE, 1}};

	always #2 clk_i = ~clk_i;

	tpc_panel_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .key_i(key_i),
		.threaded_sense_i(threaded_sense_i), .marker_sense_i(marker_sense_i),
		.ring_sense_i(ring_sense_i), .host_addr_i(host_addr_i), .seq_done_i(seq_done_i),
		.seq_fault_i(seq_fault_i), .seq_fault_code_i(seq_fault_code_i), .seq_cmd_o(seq_cmd_o),
		.seq_cmd_valid_o(seq_cmd_valid_o), .online_o(online_o), .write_block_o(write_block_o),
		.test_start_o(test_start_o), .test_num_o(test_num_o), .lamp_standby_o(lamp_standby_o),
		.lamp_power_o(lamp_power_o), .lamp_online_o(lamp_online_o), .lamp_reset_o(lamp_reset_o),
		.lamp_diag_o(lamp_diag_o), .lamp_match_o(lamp_match_o), .lamp_marker_o(lamp_marker_o),
		.write_inhibit_lamp_o(write_inhibit_lamp_o), .display_o(display_o));

	tpc_seq_model #(.DONE_DLY(20)) seq (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(seq_cmd_o),
		.cmd_valid_i(seq_cmd_valid_o), .done_o(seq_done_i));

	// record every command and test start the block issues
	always @(posedge clk_i) begin
		if (seq_cmd_valid_o === 1'b1) cmd_q.push_back(seq_cmd_o);
		if (test_start_o === 1'b1) run_q.push_back(test_num_o);
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// held for several cycles on purpose: a long hold must still be one press
	task automatic press(input int k, input int w);
		@(posedge clk_i) key_i[k] <= 1'b1;
		repeat (3) @(posedge clk_i);
		key_i[k] <= 1'b0;
		repeat (w) @(posedge clk_i);
	endtask

	// an unload empties the tape path: the threaded sensor drops until the operator threads again
	task automatic rethread;
		threaded_sense_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		threaded_sense_i <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask

	// classic single cycle; only the watchdog ends a wait for ack
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hf};
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// the whole run is some 1600 cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		report_and_stop;
	end

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({lamp_standby_o, write_block_o, display_o, test_num_o}, {2'b11, 8'h00, 8'h01});
		press(K_POWERUP, 20);
		chk({lamp_standby_o, lamp_online_o}, 2'b01);
		repeat (520) @(posedge clk_i);
		chk({lamp_power_o, write_inhibit_lamp_o, write_block_o}, 3'b111);
		ring_sense_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk({write_inhibit_lamp_o, write_block_o}, 2'b00);
		$display("power test done");
		foreach (rows[i]) begin
			marker_sense_i <= rows[i].m;
			if (rows[i].t) rethread();
			press(rows[i].k, 60);
			cmd_q.push_back(CMD_NONE);
			cmd_q.push_back(CMD_NONE);
			chk({cmd_q[0], cmd_q[1]}, {rows[i].c0, rows[i].c1});
			cmd_q.delete();
		end
		$display("table test done");
		marker_sense_i <= 1'b1;
		press(K_MOUNT, 2);
		press(K_ATTACH, 2);
		chk(online_o, 1'b0);
		repeat (40) @(posedge clk_i);
		chk({online_o, lamp_online_o, lamp_marker_o}, 3'b111);
		cmd_q.delete();
		press(K_DISMOUNT, 60);
		chk(cmd_q.size(), 0);
		@(posedge clk_i) {seq_fault_i, seq_fault_code_i} <= {1'b1, 8'h23};
		@(posedge clk_i) seq_fault_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk({lamp_reset_o, online_o, display_o}, {2'b10, 8'h23});
		// the fault itself issued a halt; only key commands count from here
		cmd_q.delete();
		press(K_MOUNT, 60);
		chk(cmd_q.size(), 0);
		press(K_RESET, 20);
		chk(lamp_reset_o, 1'b0);
		$display("online test done");
		cmd_q.delete();
		press(K_MOUNT, 2);
		press(K_RESET, 40);
		chk(cmd_q[0], CMD_REWIND);
		chk(cmd_q[1], CMD_HALT);
		wb(1'b0, REG_STATUS_OFS, 32'h0);
		chk(rd[5:2], 4'h0);
		press(K_DISMOUNT, 60);
		rethread();
		press(K_MAINT, 20);
		chk({lamp_diag_o, lamp_reset_o, lamp_match_o, display_o}, {3'b110, 8'h01});
		for (int i = 0; i < 9; i++) press(K_ADVANCE, 10);
		chk(display_o, 8'h10);
		press(K_RUN, 20);
		chk(run_q.size(), 32'd1);
		chk(run_q[0], 8'h10);
		press(K_RESET, 20);
		chk({lamp_diag_o, lamp_reset_o, lamp_match_o}, 3'b001);
		$display("diagnostic test done");
		wb(1'b1, REG_CTRL_OFS, 32'h5);
		wb(1'b0, REG_CTRL_OFS, 32'h0);
		chk(rd, 32'h5);
		wb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		repeat (4) @(posedge clk_i);
		chk(lamp_match_o, 1'b0);
		host_addr_i <= 4'h5;
		repeat (6) @(posedge clk_i);
		chk(lamp_match_o, 1'b1);
		$display("bus test done");
		// reset in mid-run: back to standby, unit address cleared
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({lamp_standby_o, lamp_power_o, lamp_match_o, online_o, display_o}, {4'b1000, 8'h00});
		wb(1'b0, REG_CTRL_OFS, 32'h0);
		chk(rd, 32'h0);
		$display("reset test done");
		report_and_stop;
	end
endmodule
